// ---- rtl/mid_decoder.sv ----
// instruction word decoder and instruction cycle sequencer
// Overview of operation
// - one 14-bit word holds opcode and operands
// - classify byte, bit, literal/control groups
// - ordinary instructions finish in one cycle
// - direct and accumulator calls take two cycles
// - all return kinds take two cycles
// - jumps, branches and taken skips take two
// - indirect program memory access adds a cycle
// - instruction cycle is four clock periods
// - file operands read before every write
// - destination bit picks accumulator or file
// - file address is seven bits, 0x00-0x7f
// - bit field selects one of eight bits
// - pointer number selects pointer zero or one
// - two-bit mode selects pre/post inc/dec
// - don't-care bits never change decoding
// - literal passed as data or target
// - flow change or true test adds nop cycle
// - pointer msb set means program memory access
`timescale 1ns/1ps
module mid_decoder #(
    parameter int CLK_PER_CYCLE = 4,    // clock periods per instruction cycle
    parameter int NUM_PTRS      = 2     // indirect pointer pairs
) (
    input  wire logic               sys_clk,      // core clock
    input  wire logic               sys_rst,      // async reset, active high
    input  wire logic [13:0]        instr_word,   // fetched instruction word
    input  wire logic               instr_valid,  // instruction word present
    input  wire logic [1:0]         ptr_msb,      // msb of each pointer register
    input  wire logic               skip_true,    // datapath skip test passed
    output logic                    instr_ready,  // word taken this clock if valid
    output mid_pkg::mid_phase_t     phase,        // current quarter of the cycle
    output mid_pkg::mid_state_t     cyc_state,    // kind of instruction cycle
    output mid_pkg::mid_dec_t       dec,          // decoded fields of current word
    output logic                    file_rd,      // file register read strobe
    output logic                    file_wr,      // result write to file strobe
    output logic                    acc_wr        // result write to accumulator
);
    import mid_pkg::*;

    // ==========================================================
    // elaboration checks
    if (CLK_PER_CYCLE != CLK_PER_IC) begin : g_bad_clk
        $error("clock periods per instruction cycle must be four");
    end
    if (NUM_PTRS != 2) begin : g_bad_ptrs
        $error("exactly two indirect pointer pairs are supported");
    end

    // ==========================================================
    // decode
    function automatic logic match(input logic [WORD_W-1:0] w,
                                   input logic [WORD_W-1:0] m,
                                   input logic [WORD_W-1:0] p);
        match = ((w & m) == p);
    endfunction

    function automatic mid_dec_t decode_word(input logic [WORD_W-1:0] w,
                                             input logic [1:0] msb);
        mid_dec_t d;
        logic     ind;
        d            = '0;
        ind          = 1'b0;
        // all fields drawn from one word
        d.subop      = w[SUB_HI:SUB_LO];
        d.faddr      = w[F_HI:F_LO];
        d.bitnum     = w[B_HI:B_LO];
        d.dest_file  = w[D_POS];
        d.ptr_mode   = w[MM_HI:MM_LO];
        d.ptr_n      = w[N_MOV_POS];
        d.lit        = w[LIT_W-1:0] & LMASK_8;
        d.op         = OP_LIT_ALU;
        // group from the two top bits
        unique case (w[GRP_HI:GRP_LO])
            2'h0:    d.grp = GRP_BYTE;
            2'h1:    d.grp = GRP_BIT;
            default: d.grp = GRP_LITCTL;
        endcase
        // masks leave don't-care bits out of every match
        if (match(w, M_FULL, P_RETURN) || match(w, M_FULL, P_INTRET)) begin
            d.op = OP_RETURN;
        end else if (match(w, M_FULL, P_CALLACC)) begin
            d.op = OP_CALL_ACC;
        end else if (match(w, M_FULL, P_JMPACC)) begin
            d.op = OP_JUMP_ACC;
        end else if (match(w, M_MOVIND, P_MOVIND)) begin
            d.op = OP_IND_MOVE;
        end else if (match(w, M_SETBANK, P_SETBANK)) begin
            // bank select writes no accumulator
            d.op  = OP_MISC;
            d.lit = w[LIT_W-1:0] & LMASK_5;
        end else if (match(w, M_ADDPTR, P_MISC)) begin
            d.op = OP_MISC;
        end else if (match(w, M_CLRACC, P_CLRACC)) begin
            d.op = OP_CLR_ACC;
            // low bits are don't-care, keep them out of the fields
            d.faddr    = '0;
            d.ptr_mode = '0;
            d.lit      = '0;
        end else if (match(w, M_HIBYTE, P_DECSKIP) || match(w, M_HIBYTE, P_INCSKIP)) begin
            d.op = OP_SKIP_BYTE;
        end else if (d.grp == GRP_BYTE) begin
            d.op = OP_ALU_F;
        end else if (match(w, M_BITOP, P_BITCLR)) begin
            d.op = OP_BIT_CLR;
        end else if (match(w, M_BITOP, P_BITSET)) begin
            d.op = OP_BIT_SET;
        end else if (d.grp == GRP_BIT) begin
            d.op = OP_SKIP_BIT;
        end else if (match(w, M_CALLGOTO, P_CALL) || match(w, M_CALLGOTO, P_GOTO)) begin
            d.op  = match(w, M_CALLGOTO, P_CALL) ? OP_CALL : OP_GOTO;
            d.lit = w[LIT_W-1:0] & LMASK_11;
        end else if (match(w, M_BRA, P_BRA)) begin
            d.op  = OP_BRANCH_REL;
            d.lit = w[LIT_W-1:0] & LMASK_9;
        end else if (match(w, M_HIBYTE, P_RETCONST)) begin
            d.op = OP_RETURN;
        end else if (match(w, M_BITOP, P_SHIFTF) || match(w, M_HIBYTE, P_SUBBF) ||
                     match(w, M_HIBYTE, P_ADDCF)) begin
            d.op  = OP_ALU_F;
            d.grp = GRP_BYTE;
        end else if (match(w, M_HIBYTE, P_MOVIDX) || match(w, M_ADDPTR, P_ADDPTR)) begin
            d.op    = match(w, M_ADDPTR, P_ADDPTR) ? OP_PTR_ADD : OP_IND_MOVE;
            d.ptr_n = w[N_LIT_POS];
            d.lit   = w[LIT_W-1:0] & LMASK_6;
        end else if (match(w, M_ADDPTR, P_SETPAGE)) begin
            d.op  = OP_MISC;
            d.lit = w[LIT_W-1:0] & LMASK_7;
        end
        // literal used as a target for calls and jumps
        d.lit_target = (d.op == OP_CALL) || (d.op == OP_GOTO) || (d.op == OP_BRANCH_REL);
        d.uses_file  = (d.op == OP_ALU_F) || (d.op == OP_SKIP_BYTE) || (d.op == OP_BIT_CLR) ||
                       (d.op == OP_BIT_SET) || (d.op == OP_SKIP_BIT);
        if ((d.grp == GRP_BIT) || !d.uses_file) begin
            d.dest_file = (d.grp == GRP_BIT);
        end
        d.writes_res = (d.uses_file && (d.op != OP_SKIP_BIT)) || (d.op == OP_LIT_ALU) ||
                       (d.op == OP_CLR_ACC);
        d.flow       = (d.op == OP_CALL) || (d.op == OP_CALL_ACC) || (d.op == OP_RETURN) ||
                       (d.op == OP_GOTO) || (d.op == OP_BRANCH_REL) || (d.op == OP_JUMP_ACC);
        d.is_skip    = (d.op == OP_SKIP_BYTE) || (d.op == OP_SKIP_BIT);
        // pointer pair of the indirect reference
        if (d.uses_file && (d.faddr == IND_LOC0)) begin
            ind     = 1'b1;
            d.ptr_n = 1'b0;
        end else if (d.uses_file && (d.faddr == IND_LOC1)) begin
            ind     = 1'b1;
            d.ptr_n = 1'b1;
        end else if (d.op == OP_IND_MOVE) begin
            ind = 1'b1;
        end
        d.pm_extra = ind && msb[d.ptr_n];
        decode_word = d;
    endfunction

    // ==========================================================
    // sequencer state
    mid_phase_t phase_reg;
    mid_phase_t phase_next;
    mid_state_t state_reg;
    mid_state_t state_next;
    mid_dec_t   dec_reg;
    mid_dec_t   dec_next;
    logic       skip_hit_reg;
    logic       skip_hit_next;
    logic       ready_reg;
    logic       ready_next;
    logic       rd_reg;
    logic       rd_next;
    logic       fwr_reg;
    logic       fwr_next;
    logic       awr_reg;
    logic       awr_next;
    logic       ends_now;
    logic       last_data;

    // next phase, cycle kind and strobes
    always_comb begin
        phase_next    = phase_reg + PH_Q2;
        state_next    = state_reg;
        dec_next      = dec_reg;
        skip_hit_next = skip_hit_reg;
        unique case (state_reg)
            ST_IDLE:  ends_now = 1'b1;
            // plain instructions end after this cycle
            ST_EXEC:  ends_now = !dec_reg.pm_extra && !dec_reg.flow &&
                                 !(dec_reg.is_skip && skip_true);
            ST_EXTRA: ends_now = !dec_reg.flow && !skip_hit_reg;
            ST_FLUSH: ends_now = 1'b1;
        endcase
        // taken skip remembered at the third phase
        if ((phase_reg == PH_Q3) && (state_reg == ST_EXEC) && dec_reg.is_skip && skip_true) begin
            skip_hit_next = 1'b1;
        end
        ready_next = (phase_reg == PH_Q3) && ends_now;
        if (phase_reg == PH_Q4) begin
            if (ready_reg) begin
                skip_hit_next = 1'b0;
                if (instr_valid) begin
                    dec_next   = decode_word(instr_word, ptr_msb);
                    state_next = ST_EXEC;
                end else begin
                    state_next = ST_IDLE;
                end
            end else if (state_reg == ST_EXEC) begin
                // program memory read cycle before the flush
                state_next = dec_reg.pm_extra ? ST_EXTRA : ST_FLUSH;
            end else begin
                // third cycle runs as a no-operation
                state_next = ST_FLUSH;
            end
        end
        last_data = ((state_reg == ST_EXEC) && !dec_reg.pm_extra) || (state_reg == ST_EXTRA);
        // read the file operand in the second phase
        rd_next   = (phase_reg == PH_Q1) && (state_reg == ST_EXEC) && dec_reg.uses_file;
        // result steered by the destination bit
        fwr_next  = (phase_reg == PH_Q3) && last_data && dec_reg.writes_res && dec_reg.dest_file;
        awr_next  = (phase_reg == PH_Q3) && last_data && dec_reg.writes_res && !dec_reg.dest_file;
    end

    // sequencer registers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg    <= PH_Q1;
            state_reg    <= ST_IDLE;
            dec_reg      <= '0;
            skip_hit_reg <= 1'b0;
            ready_reg    <= 1'b0;
            rd_reg       <= 1'b0;
            fwr_reg      <= 1'b0;
            awr_reg      <= 1'b0;
        end else begin
            phase_reg    <= phase_next;
            state_reg    <= state_next;
            dec_reg      <= dec_next;
            skip_hit_reg <= skip_hit_next;
            ready_reg    <= ready_next;
            rd_reg       <= rd_next;
            fwr_reg      <= fwr_next;
            awr_reg      <= awr_next;
        end
    end

    // outputs straight from flops
    assign instr_ready = ready_reg;
    assign phase       = phase_reg;
    assign cyc_state   = state_reg;
    assign dec         = dec_reg;
    assign file_rd     = rd_reg;
    assign file_wr     = fwr_reg;
    assign acc_wr      = awr_reg;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_exec_start;
        (state_reg == ST_EXEC) && (phase_reg == PH_Q1);
    endsequence
    sequence s_flush_end;
        (state_reg == ST_FLUSH) ##3 ready_reg;
    endsequence

    AST_PHASE_WRAP: assert property ((phase_reg == PH_Q4) |=> (phase_reg == PH_Q1))
        else $error("phase did not wrap to first quarter");
    AST_ONE_CYCLE: assert property (s_exec_start ##0 (!dec_reg.flow && !dec_reg.pm_extra &&
        !dec_reg.is_skip) |-> !ready_reg [*3] ##1 ready_reg)
        else $error("plain instruction not done in one cycle");
    AST_CALL_TWO: assert property (s_exec_start ##0 (((dec_reg.op == OP_CALL) ||
        (dec_reg.op == OP_CALL_ACC)) && !dec_reg.pm_extra) |-> ##4 s_flush_end)
        else $error("call did not take two cycles");
    AST_RET_TWO: assert property (s_exec_start ##0 (dec_reg.op == OP_RETURN)
        |-> ##4 s_flush_end)
        else $error("return did not take two cycles");
    AST_FLOW_TWO: assert property (s_exec_start ##0 (dec_reg.flow && !dec_reg.pm_extra)
        |-> ##4 s_flush_end)
        else $error("flow change did not take two cycles");
    // program memory access adds a cycle
    AST_PM_EXTRA: assert property (s_exec_start ##0 dec_reg.pm_extra
        |-> ##4 ((state_reg == ST_EXTRA) && (phase_reg == PH_Q1)))
        else $error("indirect program memory cycle missing");
    AST_READ_FIRST: assert property (s_exec_start ##0 dec_reg.uses_file
        |=> rd_reg ##1 !rd_reg)
        else $error("file operand not read");
    AST_DEST: assert property ((fwr_reg |-> dec_reg.dest_file) and
        (awr_reg |-> !dec_reg.dest_file && !fwr_reg))
        else $error("result written to wrong destination");
    AST_SKIP_NOP: assert property (((state_reg == ST_EXEC) && (phase_reg == PH_Q3) &&
        dec_reg.is_skip && skip_true && !dec_reg.pm_extra)
        |-> ##2 ((state_reg == ST_FLUSH) && (phase_reg == PH_Q1)))
        else $error("taken skip did not insert a no-operation");
endmodule

// ---- rtl/mid_pkg.sv ----
// package: field layout, opcode patterns, phases, states and decoded word type
package mid_pkg;
    // ==========================================================
    // word and field layout
    localparam int WORD_W     = 14;
    localparam int FADDR_W    = 7;
    localparam int BITN_W     = 3;
    localparam int LIT_W      = 11;
    localparam int F_LO       = 0;
    localparam int F_HI       = 6;
    localparam int D_POS      = 7;
    localparam int B_LO       = 7;
    localparam int B_HI       = 9;
    localparam int SUB_LO     = 8;
    localparam int SUB_HI     = 11;
    localparam int GRP_LO     = 12;
    localparam int GRP_HI     = 13;
    localparam int MM_LO      = 0;
    localparam int MM_HI      = 1;
    localparam int N_MOV_POS  = 2;
    localparam int N_LIT_POS  = 6;
    localparam int CLK_PER_IC = 4;
    // ==========================================================
    // literal widths as masks
    localparam logic [LIT_W-1:0] LMASK_11 = 11'h7ff;
    localparam logic [LIT_W-1:0] LMASK_9  = 11'h1ff;
    localparam logic [LIT_W-1:0] LMASK_8  = 11'h0ff;
    localparam logic [LIT_W-1:0] LMASK_7  = 11'h07f;
    localparam logic [LIT_W-1:0] LMASK_6  = 11'h03f;
    localparam logic [LIT_W-1:0] LMASK_5  = 11'h01f;
    // ==========================================================
    // indirect access locations in every bank
    localparam logic [FADDR_W-1:0] IND_LOC0 = 7'h00;
    localparam logic [FADDR_W-1:0] IND_LOC1 = 7'h01;
    // ==========================================================
    // opcode masks and patterns
    localparam logic [WORD_W-1:0] M_CALLGOTO = 14'h3800;
    localparam logic [WORD_W-1:0] P_CALL     = 14'h2000;
    localparam logic [WORD_W-1:0] P_GOTO     = 14'h2800;
    localparam logic [WORD_W-1:0] M_BRA      = 14'h3e00;
    localparam logic [WORD_W-1:0] P_BRA      = 14'h3200;
    localparam logic [WORD_W-1:0] M_HIBYTE   = 14'h3f00;
    localparam logic [WORD_W-1:0] P_RETCONST = 14'h3400;
    localparam logic [WORD_W-1:0] P_MOVIDX   = 14'h3f00;
    localparam logic [WORD_W-1:0] P_DECSKIP  = 14'h0b00;
    localparam logic [WORD_W-1:0] P_INCSKIP  = 14'h0f00;
    localparam logic [WORD_W-1:0] M_FULL     = 14'h3fff;
    localparam logic [WORD_W-1:0] P_RETURN   = 14'h0008;
    localparam logic [WORD_W-1:0] P_INTRET   = 14'h0009;
    localparam logic [WORD_W-1:0] P_CALLACC  = 14'h000a;
    localparam logic [WORD_W-1:0] P_JMPACC   = 14'h000b;
    localparam logic [WORD_W-1:0] M_MOVIND   = 14'h3ff0;
    localparam logic [WORD_W-1:0] P_MOVIND   = 14'h0010;
    localparam logic [WORD_W-1:0] M_ADDPTR   = 14'h3f80;
    localparam logic [WORD_W-1:0] P_ADDPTR   = 14'h3100;
    localparam logic [WORD_W-1:0] P_SETPAGE  = 14'h3180;
    localparam logic [WORD_W-1:0] M_SETBANK  = 14'h3fe0;
    localparam logic [WORD_W-1:0] P_SETBANK  = 14'h0020;
    localparam logic [WORD_W-1:0] M_CLRACC   = 14'h3ffc;
    localparam logic [WORD_W-1:0] P_CLRACC   = 14'h0100;
    localparam logic [WORD_W-1:0] P_MISC     = 14'h0000;
    localparam logic [WORD_W-1:0] M_BITOP    = 14'h3c00;
    localparam logic [WORD_W-1:0] P_BITCLR   = 14'h1000;
    localparam logic [WORD_W-1:0] P_BITSET   = 14'h1400;
    localparam logic [WORD_W-1:0] P_SKIPCLR  = 14'h1800;
    localparam logic [WORD_W-1:0] P_SKIPSET  = 14'h1c00;
    // byte-oriented file operations that sit in the upper opcode group
    localparam logic [WORD_W-1:0] P_SHIFTF   = 14'h3400;
    localparam logic [WORD_W-1:0] P_SUBBF    = 14'h3b00;
    localparam logic [WORD_W-1:0] P_ADDCF    = 14'h3d00;
    // ==========================================================
    // phases of one instruction cycle
    typedef logic [1:0] mid_phase_t;
    localparam mid_phase_t PH_Q1 = 2'h0;
    localparam mid_phase_t PH_Q2 = 2'h1;
    localparam mid_phase_t PH_Q3 = 2'h2;
    localparam mid_phase_t PH_Q4 = 2'h3;
    // ==========================================================
    // groups, operation classes and sequencer states
    typedef enum logic [1:0] {GRP_BYTE = 2'h0, GRP_BIT = 2'h1, GRP_LITCTL = 2'h2} mid_grp_t;
    typedef enum logic [3:0] {
        OP_ALU_F, OP_CLR_ACC, OP_SKIP_BYTE, OP_BIT_CLR, OP_BIT_SET, OP_SKIP_BIT,
        OP_LIT_ALU, OP_CALL, OP_GOTO, OP_BRANCH_REL, OP_RETURN, OP_CALL_ACC,
        OP_JUMP_ACC, OP_IND_MOVE, OP_PTR_ADD, OP_MISC
    } mid_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_EXTRA = 2'b11, ST_FLUSH = 2'b10
    } mid_state_t;
    typedef struct packed {
        mid_grp_t           grp;
        mid_op_t            op;
        logic [3:0]         subop;
        logic [FADDR_W-1:0] faddr;
        logic [BITN_W-1:0]  bitnum;
        logic [LIT_W-1:0]   lit;
        logic               lit_target;
        logic               dest_file;
        logic               ptr_n;
        logic [1:0]         ptr_mode;
        logic               uses_file;
        logic               writes_res;
        logic               flow;
        logic               is_skip;
        logic               pm_extra;
    } mid_dec_t;
endpackage

// ---- dv/mid_pm_model.sv ----
// program memory model that feeds instruction words to the decoder
`timescale 1ns/1ps
module mid_pm_model (
    input  wire logic        sys_clk,     // core clock
    input  wire logic        start,       // restart from word zero
    input  wire logic        slow,        // insert wait cycles between words
    input  wire logic        instr_ready, // decoder takes a word
    output logic [13:0]      instr_word,  // word offered to the decoder
    output logic             instr_valid, // word present
    output logic [1:0]       ptr_msb      // pointer msbs that go with the word
);
    logic [13:0] mem [17];
    logic [1:0]  msb [17];
    int          n_words;
    int          idx;
    int          wait_n;
    initial begin
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        ptr_msb = 2'h0;
        n_words = 0;
        idx = 0;
        wait_n = 0;
    end
    // ==========================================================
    // offer one word, hold it until taken; scramble lines when idle
    always @(posedge sys_clk) begin
        if (start) begin
            idx = 0;
            wait_n = 0;
        end else if (instr_valid && instr_ready) begin
            idx++;
            wait_n = slow ? 5 : 0;
        end else if (wait_n > 0) begin
            wait_n--;
        end
        #1;
        instr_valid = (idx < n_words) && (wait_n == 0);
        instr_word = instr_valid ? mem[idx] : ~instr_word;
        ptr_msb = instr_valid ? msb[idx] : ~ptr_msb;
    end
endmodule

// ---- dv/mcu_instruction_decode_timing_test.sv ----
// self-checking bench for the instruction decoder and cycle sequencer
`timescale 1ns/1ps
module mcu_instruction_decode_timing_test;
    import mid_pkg::*;
    logic        sys_clk;
    logic        sys_rst;
    logic        skip_true;
    logic        start;
    logic        slow;
    logic [13:0] instr_word;
    logic        instr_valid;
    logic [1:0]  ptr_msb;
    logic        instr_ready;
    mid_phase_t  phase;
    mid_state_t  cyc_state;
    mid_dec_t    dec;
    logic        file_rd;
    logic        file_wr;
    logic        acc_wr;
    int          bad_count;
    int          n_checks;
    int          cyc_n;
    int          n_take;
    int          tk [17];
    int          rd_n [17];
    int          wr_n [17];
    int          acc_n [17];
    logic        skp [17];
    mid_dec_t    dq [17];

    mid_decoder DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_word(instr_word),
        .instr_valid(instr_valid), .ptr_msb(ptr_msb), .skip_true(skip_true),
        .instr_ready(instr_ready), .phase(phase), .cyc_state(cyc_state), .dec(dec),
        .file_rd(file_rd), .file_wr(file_wr), .acc_wr(acc_wr));
    mid_pm_model u_pm (.sys_clk(sys_clk), .start(start), .slow(slow),
        .instr_ready(instr_ready), .instr_word(instr_word),
        .instr_valid(instr_valid), .ptr_msb(ptr_msb));

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================================
    // monitor: time each take, count strobes per instruction
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n > 3000) begin
            bad_count++;
            report_and_stop();
        end
        if (n_take > 0) begin
            rd_n[n_take-1] += int'(file_rd);
            wr_n[n_take-1] += int'(file_wr);
            acc_n[n_take-1] += int'(acc_wr);
            dq[n_take-1] = dec;
        end
        if (instr_ready && instr_valid && !sys_rst && n_take < 17) begin
            chk(phase, PH_Q4); // take only in last quarter
            tk[n_take] = cyc_n;
            skip_true <= #1 skp[n_take];
            n_take++;
        end
    end

    task automatic ld(input int i, input logic [13:0] w, input logic [1:0] m, input logic s);
        u_pm.mem[i] = w;
        u_pm.msb[i] = m;
        skp[i] = s;
    endtask

    // run n loaded words plus a one-cycle filler so the last one is timed
    task automatic run_prog(input int n);
        ld(n, 14'h0000, 2'h0, 1'b0);
        u_pm.n_words = n + 1;
        n_take = 0;
        for (int i = 0; i < 17; i++) begin
            rd_n[i] = 0;
            wr_n[i] = 0;
            acc_n[i] = 0;
        end
        start = 1'b1;
        @(posedge sys_clk);
        #1 start = 1'b0;
        for (int i = 0; i < 600 && n_take <= n; i++)
            @(posedge sys_clk);
        repeat (12) @(posedge sys_clk);
        #1;
        chk(n_take, n + 1); // one word per instruction
    endtask

    task automatic t_fields;
        logic [13:0] w [11] = '{14'h077f, 14'h16d1, 14'h30a5, 14'h2123, 14'h0017,
            14'h0100, 14'h0103, 14'h0010, 14'h0011, 14'h0012, 14'h0013};
        for (int i = 0; i < 11; i++)
            ld(i, w[i], 2'h0, 1'b0);
        run_prog(11);
        chk(dq[0].grp, GRP_BYTE); // byte group
        chk(dq[0].faddr, 7'h7f); // top file address
        chk(dq[0].dest_file, 1'b0); // result to accumulator
        chk(dq[1].grp, GRP_BIT); // bit group
        chk(dq[1].bitnum, 3'h5); // bit number
        chk(dq[1].faddr, 7'h51); // file address
        chk(dq[2].grp, GRP_LITCTL); // literal group
        chk(dq[2].lit, 11'h0a5); // constant data
        chk(dq[2].lit_target, 1'b0); // data not target
        chk(dq[3].lit, 11'h123); // call target
        chk(dq[3].lit_target, 1'b1); // target flag
        chk(dq[4].ptr_n, 1'b1); // second pointer
        chk(dq[6] === dq[5], 1'b1); // ignored low bits
        for (int i = 0; i < 4; i++)
            chk(dq[7+i].ptr_mode, i); // every update mode
        $display("test fields done");
    endtask

    task automatic t_timing;
        logic [13:0] w [14] = '{14'h07a0, 14'h3055, 14'h0020, 14'h2012, 14'h000a,
            14'h0008, 14'h0009, 14'h3405, 14'h2812, 14'h3203, 14'h000b, 14'h3e07,
            14'h3145, 14'h3185};
        int          c [14] = '{1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 1, 1, 1};
        for (int i = 0; i < 14; i++)
            ld(i, w[i], 2'h0, 1'b0);
        run_prog(14);
        for (int i = 0; i < 14; i++)
            chk(tk[i+1] - tk[i], 4 * c[i]); // spacing
        $display("test timing done");
    endtask

    // indirect file operands and moves, pointer msb in program memory
    task automatic t_indirect;
        logic [13:0] w [7] = '{14'h0780, 14'h0780, 14'h0781, 14'h0781, 14'h0012, 14'h0016,
            14'h3f45};
        logic [1:0]  m [7] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1, 2'h2};
        int          c [7] = '{2, 1, 2, 1, 2, 1, 2};
        for (int i = 0; i < 7; i++)
            ld(i, w[i], m[i], 1'b0);
        run_prog(7);
        for (int i = 0; i < 7; i++)
            chk(tk[i+1] - tk[i], 4 * c[i]); // extra cycle
        chk(wr_n[0], 1); // single write after extra cycle
        $display("test indirect done");
    endtask

    task automatic t_skip;
        logic [13:0] w [6] = '{14'h0ba0, 14'h0ba0, 14'h0fa0, 14'h1ca0, 14'h18a0, 14'h1ca0};
        logic        s [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        int          c [6] = '{2, 1, 2, 2, 1, 1};
        for (int i = 0; i < 6; i++)
            ld(i, w[i], 2'h0, s[i]);
        run_prog(6);
        for (int i = 0; i < 6; i++)
            chk(tk[i+1] - tk[i], 4 * c[i]); // taken skip nop
        chk(wr_n[0], 1); // skip result to file
        chk(rd_n[3], 1); // bit test reads file
        $display("test skip done");
    endtask

    // strobes with a slow memory: read for file operands only, write per destination
    task automatic t_strobes;
        logic [13:0] w [7] = '{14'h07a0, 14'h0720, 14'h00a0, 14'h01a0, 14'h14a0, 14'h3055,
            14'h35a0};
        logic [2:0]  e [7] = '{3'h6, 3'h5, 3'h6, 3'h6, 3'h6, 3'h1, 3'h6};
        for (int i = 0; i < 7; i++)
            ld(i, w[i], 2'h0, 1'b0);
        slow = 1'b1;
        run_prog(7);
        slow = 1'b0;
        for (int i = 0; i < 7; i++) begin
            chk(rd_n[i], e[i][2]); // file operand read count
            chk(wr_n[i], e[i][1]); // file destination
            chk(acc_n[i], e[i][0]); // accumulator destination
        end
        $display("test strobes done");
    endtask

    initial begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        skip_true = 1'b0;
        start = 1'b0;
        slow = 1'b0;
        bad_count = 0;
        n_checks = 0;
        cyc_n = 0;
        n_take = 0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(phase, PH_Q1); // phase held at first quarter
        chk(cyc_state, ST_IDLE); // no instruction under reset
        sys_rst = 1'b0;
        t_fields();
        t_timing();
        t_indirect();
        t_skip();
        t_strobes();
        report_and_stop();
    end
endmodule
